// [design/sdsc_consts.svh]
`ifndef SDSC_CONSTS_SVH
`define SDSC_CONSTS_SVH

`define SDSC_ADDR_BASE 6'h20
`define SDSC_CMD_READ_TRH 7'h00
`define SDSC_CMD_READ_RH 7'h08
`define SDSC_CMD_RESET 7'h0F
`define SDSC_CMD_HEAT_ON 7'h02
`define SDSC_CMD_HEAT_OFF 7'h01
`define SDSC_CMD_READ_DIAG 7'h04
`define SDSC_CRC_POLY 8'h31
`define SDSC_CRC_INIT 8'h00
`define SDSC_BIT_NVM 7
`define SDSC_BIT_HCLIP 6
`define SDSC_BIT_HHIGH 5
`define SDSC_BIT_HLOW 4
`define SDSC_BIT_TCLIP 3
`define SDSC_BIT_THIGH 2
`define SDSC_BIT_TLOW 1
`define SDSC_BIT_HEAT 0
`define SDSC_IDLE_BYTE 8'hFF

`endif

// [design/sdsc_crc8.sv]
`timescale 1ns/1ps
`include "sdsc_consts.svh"

module sdsc_crc8 (
	input wire logic mclk,
	input wire logic srst,
	input wire logic valid,
	input wire logic clear,
	input wire logic [7:0] data,
	output logic [7:0] crc_q
);
	function automatic logic [7:0] sdsc_step(input logic [7:0] c_in, input logic [7:0] d);
		logic [7:0] c;
		logic fb;
		c = c_in;
		for (int i = 7; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0} ^ (fb ? `SDSC_CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	// Most significant bit first, no reflection and no final inversion.
	always_ff @(posedge mclk) begin
		if (srst) begin
			crc_q <= `SDSC_CRC_INIT;
		end else if (valid) begin
			crc_q <= sdsc_step(clear ? `SDSC_CRC_INIT : crc_q, data);
		end
	end

	property p_crc_vector;
		@(posedge mclk) disable iff (srst) (valid && clear && data == 8'hDC) |=> crc_q == 8'h79;
	endproperty
	a_crc_vector: assert property (p_crc_vector) else $error("crc of 0xDC is not 0x79");

	property p_crc_init;
		@(posedge mclk) disable iff (srst) (valid && clear && data == 8'h00) |=> crc_q == 8'h00;
	endproperty
	a_crc_init: assert property (p_crc_init) else $error("crc does not start from zero");

	property p_crc_pair;
		@(posedge mclk) disable iff (srst)
			(valid && clear && data == 8'h68) ##[1:200] (valid && !clear && data == 8'h3A) |=> crc_q == 8'h7C;
	endproperty
	a_crc_pair: assert property (p_crc_pair) else $error("two byte crc is not 0x7C");
endmodule

// [design/sdsc_pkg.sv]
package sdsc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_RX_DONE,
		ST_ACK,
		ST_TX,
		ST_MACK,
		ST_MACK_OK
	} sdsc_state_type;

	typedef enum logic [1:0] {
		MODE_NONE,
		MODE_DIAG,
		MODE_TRH,
		MODE_RH
	} sdsc_mode_type;
endpackage

// [design/sdsc_top.sv]
`timescale 1ns/1ps
`include "sdsc_consts.svh"

// Function
// - Bit 7 flags memory checksum failure.
// - Bit 6 flags humidity output clipped.
// - Bit 5 flags humidity above 120 %RH.
// - Bit 4 flags humidity below -10 %RH.
// - Bit 3 flags temperature output clipped.
// - Bit 2 flags temperature above 150 C.
// - Bit 1 flags temperature below -50 C.
// - Bit 0 shows heater on.
// - Heater-off or reset command clears heater.
// - CRC-8 polynomial x^8+x^5+x^4+1.
// - CRC starts at zero, no final XOR.
// - CRC covers every returned data field.
// - CRC is MSB-first remainder with zero pad.
// - Each 16-bit measurement gets its own CRC.
module sdsc_top #(
	parameter int DATA_W = 16
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda_level,
	input wire logic addr_sel,
	input wire logic nonvolatile_check_fail,
	input wire logic hum_clipped,
	input wire logic hum_above_range,
	input wire logic hum_below_range,
	input wire logic tmp_clipped,
	input wire logic tmp_above_range,
	input wire logic tmp_below_range,
	input wire logic [DATA_W-1:0] temp_value,
	input wire logic [DATA_W-1:0] hum_value,
	output logic sda_data,
	output logic sda_oe,
	output logic heater_on,
	output logic soft_reset
);
	if (DATA_W != 16) begin
		$error("measurement width must be 16");
	end

	logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, sel_s1, sel_s2;
	logic scl_rise, scl_fall, start_det, stop_det;
	sdsc_pkg::sdsc_state_type state_q;
	sdsc_pkg::sdsc_mode_type mode_q;
	logic [2:0] bit_cnt_q, byte_idx_q;
	logic [3:0] bit_tx_q;
	logic [7:0] rx_sh_q, tx_sh_q, status_byte, tx_byte, crc_q;
	logic is_addr_q, read_q, tx_is_crc, tx_first, tx_load, cmd_strobe, addr_match;

	// Pins arrive from the bus clock domain; the first stage feeds only the second.
	always_ff @(posedge mclk) begin
		if (srst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
			sel_s1 <= 1'b0;
			sel_s2 <= 1'b0;
		end else begin
			scl_s1 <= scl;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= sda_level;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
			sel_s1 <= addr_sel;
			sel_s2 <= sel_s1;
		end
	end

	assign scl_rise = scl_s2 & ~scl_d;
	assign scl_fall = ~scl_s2 & scl_d;
	assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
	assign addr_match = rx_sh_q[7:1] == {`SDSC_ADDR_BASE, sel_s2};
	assign cmd_strobe = (state_q == sdsc_pkg::ST_RX_DONE) && scl_fall && !is_addr_q;
	assign tx_load = scl_fall && (((state_q == sdsc_pkg::ST_ACK) && read_q) || (state_q == sdsc_pkg::ST_MACK_OK));

	always_comb begin
		status_byte = 8'h00;
		status_byte[`SDSC_BIT_NVM] = nonvolatile_check_fail;
		status_byte[`SDSC_BIT_HCLIP] = hum_clipped;
		status_byte[`SDSC_BIT_HHIGH] = hum_above_range;
		status_byte[`SDSC_BIT_HLOW] = hum_below_range;
		status_byte[`SDSC_BIT_TCLIP] = tmp_clipped;
		status_byte[`SDSC_BIT_THIGH] = tmp_above_range;
		status_byte[`SDSC_BIT_TLOW] = tmp_below_range;
		status_byte[`SDSC_BIT_HEAT] = heater_on;
	end

	// Each returned field is data bytes then one CRC byte over that field alone.
	always_comb begin
		tx_byte = `SDSC_IDLE_BYTE;
		tx_is_crc = 1'b0;
		tx_first = 1'b0;
		case (mode_q)
			sdsc_pkg::MODE_DIAG: begin
				tx_first = byte_idx_q == 3'd0;
				tx_is_crc = byte_idx_q == 3'd1;
				if (byte_idx_q == 3'd0) begin
					tx_byte = status_byte;
				end else if (byte_idx_q == 3'd1) begin
					tx_byte = crc_q;
				end
			end
			sdsc_pkg::MODE_TRH: begin
				tx_first = (byte_idx_q == 3'd0) || (byte_idx_q == 3'd3);
				tx_is_crc = (byte_idx_q == 3'd2) || (byte_idx_q == 3'd5);
				case (byte_idx_q)
					3'd0: tx_byte = temp_value[15:8];
					3'd1: tx_byte = temp_value[7:0];
					3'd2: tx_byte = crc_q;
					3'd3: tx_byte = hum_value[15:8];
					3'd4: tx_byte = hum_value[7:0];
					3'd5: tx_byte = crc_q;
					default: tx_byte = `SDSC_IDLE_BYTE;
				endcase
			end
			sdsc_pkg::MODE_RH: begin
				tx_first = byte_idx_q == 3'd0;
				tx_is_crc = byte_idx_q == 3'd2;
				case (byte_idx_q)
					3'd0: tx_byte = hum_value[15:8];
					3'd1: tx_byte = hum_value[7:0];
					3'd2: tx_byte = crc_q;
					default: tx_byte = `SDSC_IDLE_BYTE;
				endcase
			end
			default: tx_byte = `SDSC_IDLE_BYTE;
		endcase
	end

	// Every data byte feeds the CRC as it is loaded, 0xFF included, except in MODE_NONE, so the check byte is ready early.
	sdsc_crc8 u_crc (
		.mclk(mclk),
		.srst(srst),
		.valid(tx_load && !tx_is_crc && mode_q != sdsc_pkg::MODE_NONE),
		.clear(tx_first),
		.data(tx_byte),
		.crc_q(crc_q)
	);

	// Bytes are taken on rising clock edges and the data line is changed only after falling ones.
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= sdsc_pkg::ST_IDLE;
			bit_cnt_q <= 3'd0;
			bit_tx_q <= 4'd0;
			rx_sh_q <= 8'h00;
			tx_sh_q <= 8'h00;
			is_addr_q <= 1'b0;
			read_q <= 1'b0;
			byte_idx_q <= 3'd0;
			sda_oe <= 1'b0;
		end else if (start_det) begin
			state_q <= sdsc_pkg::ST_RX;
			bit_cnt_q <= 3'd0;
			is_addr_q <= 1'b1;
			sda_oe <= 1'b0;
		end else if (stop_det) begin
			state_q <= sdsc_pkg::ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (state_q)
				sdsc_pkg::ST_RX: if (scl_rise) begin
					rx_sh_q <= {rx_sh_q[6:0], sda_s2};
					bit_cnt_q <= bit_cnt_q + 3'd1;
					if (bit_cnt_q == 3'd7) begin
						state_q <= sdsc_pkg::ST_RX_DONE;
					end
				end
				sdsc_pkg::ST_RX_DONE: if (scl_fall) begin
					if (!is_addr_q || addr_match) begin
						sda_oe <= 1'b1;
						state_q <= sdsc_pkg::ST_ACK;
						if (is_addr_q) begin
							read_q <= rx_sh_q[0];
							byte_idx_q <= 3'd0;
						end
					end else begin
						state_q <= sdsc_pkg::ST_IDLE;
					end
				end
				sdsc_pkg::ST_ACK: if (scl_fall) begin
					is_addr_q <= 1'b0;
					bit_cnt_q <= 3'd0;
					if (read_q) begin
						sda_oe <= ~tx_byte[7];
						tx_sh_q <= {tx_byte[6:0], 1'b1};
						bit_tx_q <= 4'd1;
						byte_idx_q <= byte_idx_q + 3'd1;
						state_q <= sdsc_pkg::ST_TX;
					end else begin
						sda_oe <= 1'b0;
						read_q <= 1'b0;
						state_q <= sdsc_pkg::ST_RX;
					end
				end
				sdsc_pkg::ST_TX: if (scl_fall) begin
					if (bit_tx_q == 4'd8) begin
						sda_oe <= 1'b0;
						state_q <= sdsc_pkg::ST_MACK;
					end else begin
						sda_oe <= ~tx_sh_q[7];
						tx_sh_q <= {tx_sh_q[6:0], 1'b1};
						bit_tx_q <= bit_tx_q + 4'd1;
					end
				end
				sdsc_pkg::ST_MACK: if (scl_rise) begin
					// A missing acknowledge ends our drive; the controller must then send a stop.
					state_q <= sda_s2 ? sdsc_pkg::ST_IDLE : sdsc_pkg::ST_MACK_OK;
				end
				sdsc_pkg::ST_MACK_OK: if (scl_fall) begin
					sda_oe <= ~tx_byte[7];
					tx_sh_q <= {tx_byte[6:0], 1'b1};
					bit_tx_q <= 4'd1;
					byte_idx_q <= (byte_idx_q == 3'd7) ? byte_idx_q : byte_idx_q + 3'd1;
					state_q <= sdsc_pkg::ST_TX;
				end
				default: state_q <= sdsc_pkg::ST_IDLE;
			endcase
		end
	end

	// Unknown commands leave the read mode at none, so a later read returns released bytes.
	always_ff @(posedge mclk) begin
		if (srst) begin
			mode_q <= sdsc_pkg::MODE_NONE;
		end else if (cmd_strobe) begin
			case (rx_sh_q[7:1])
				`SDSC_CMD_READ_DIAG: mode_q <= sdsc_pkg::MODE_DIAG;
				`SDSC_CMD_READ_TRH: mode_q <= sdsc_pkg::MODE_TRH;
				`SDSC_CMD_READ_RH: mode_q <= sdsc_pkg::MODE_RH;
				default: mode_q <= sdsc_pkg::MODE_NONE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		sda_data <= 1'b0;
		if (srst) begin
			heater_on <= 1'b0;
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= cmd_strobe && rx_sh_q[7:1] == `SDSC_CMD_RESET;
			if (cmd_strobe && rx_sh_q[7:1] == `SDSC_CMD_HEAT_ON) begin
				heater_on <= 1'b1;
			end else if (cmd_strobe && (rx_sh_q[7:1] == `SDSC_CMD_HEAT_OFF || rx_sh_q[7:1] == `SDSC_CMD_RESET)) begin
				heater_on <= 1'b0;
			end
		end
	end

	property p_heat_on;
		@(posedge mclk) disable iff (srst) (cmd_strobe && rx_sh_q[7:1] == `SDSC_CMD_HEAT_ON) |=> heater_on;
	endproperty
	a_heat_on: assert property (p_heat_on) else $error("heater did not turn on");
	property p_heat_off;
		@(posedge mclk) disable iff (srst)
			(cmd_strobe && (rx_sh_q[7:1] == `SDSC_CMD_HEAT_OFF || rx_sh_q[7:1] == `SDSC_CMD_RESET)) |=> !heater_on;
	endproperty
	a_heat_off: assert property (p_heat_off) else $error("heater did not turn off");
	property p_status_first;
		@(posedge mclk) disable iff (srst)
			(tx_load && mode_q == sdsc_pkg::MODE_DIAG && byte_idx_q == 3'd0)
				|=> sda_oe == ~$past(nonvolatile_check_fail) && tx_sh_q[7:1] == $past(status_byte[6:0]);
	endproperty
	a_status_first: assert property (p_status_first) else $error("status byte not sent first");
	property p_crc_second;
		@(posedge mclk) disable iff (srst)
			(tx_load && mode_q == sdsc_pkg::MODE_DIAG && byte_idx_q == 3'd1)
				|=> sda_oe == ~$past(crc_q[7]) && tx_sh_q[7:1] == $past(crc_q[6:0]);
	endproperty
	a_crc_second: assert property (p_crc_second) else $error("crc byte not sent after status");
	property p_nack_release;
		@(posedge mclk) disable iff (srst)
			(state_q == sdsc_pkg::ST_MACK && scl_rise && sda_s2 && !start_det && !stop_det)
				|=> state_q == sdsc_pkg::ST_IDLE && !sda_oe;
	endproperty
	a_nack_release: assert property (p_nack_release) else $error("data line held after nack");
	property p_rh_crc_slot;
		@(posedge mclk) disable iff (srst)
			(tx_load && mode_q == sdsc_pkg::MODE_RH && byte_idx_q == 3'd2)
				|=> sda_oe == ~$past(crc_q[7]) && tx_sh_q[7:1] == $past(crc_q[6:0]);
	endproperty
	a_rh_crc_slot: assert property (p_rh_crc_slot) else $error("humidity crc not in third byte");
endmodule

// [testbench/sdsc_ctrl_model.sv]
`timescale 1ns/1ps
module sdsc_ctrl_model (
	input wire logic mclk,
	input wire logic sda_level,
	output logic scl,
	output logic sda_pull
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic q();
		repeat (4) @(posedge mclk);
	endtask
	task automatic start();
		sda_pull <= 1'b1;
		q();
		scl <= 1'b0;
	endtask
	task automatic stop();
		q();
		sda_pull <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda_pull <= 1'b0;
		q();
	endtask
	// Data moves only in mid-low so it never looks like a start or stop.
	task automatic bit_io(input logic b, output logic r);
		q();
		sda_pull <= ~b;
		q();
		scl <= 1'b1;
		q();
		r = sda_level;
		q();
		scl <= 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
$display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
	logic mclk, srst, addr_sel, scl, sda_pull, sda_oe, sda_data, heater_on, soft_reset, sda_level, ack;
	logic [6:0] flags;
	logic [6:0] dev_addr;
	logic [15:0] temp_value, hum_value;
	logic [7:0] rb [6];
	logic [7:0] exp6 [6] = '{8'h68, 8'h3A, 8'h7C, 8'h4E, 8'h85, 8'h6B};
	int error_cnt, compares, resets;
	// A released line reads high through the pull-up, never the last driven value.
	assign sda_level = ~(sda_pull | (sda_oe & ~sda_data));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) if (soft_reset === 1'b1) resets++;
	sdsc_ctrl_model sdsc_ctrl_model_inst (.mclk(mclk), .sda_level(sda_level), .scl(scl), .sda_pull(sda_pull));
	sdsc_top #(.DATA_W(16)) sdsc_top_inst (.mclk(mclk), .srst(srst), .scl(scl), .sda_level(sda_level),
		.addr_sel(addr_sel), .nonvolatile_check_fail(flags[6]), .hum_clipped(flags[5]),
		.hum_above_range(flags[4]), .hum_below_range(flags[3]), .tmp_clipped(flags[2]),
		.tmp_above_range(flags[1]), .tmp_below_range(flags[0]), .temp_value(temp_value),
		.hum_value(hum_value), .sda_data(sda_data), .sda_oe(sda_oe), .heater_on(heater_on),
		.soft_reset(soft_reset));
	function automatic logic [7:0] crc8(input logic [15:0] m, input int nb);
		logic [7:0] c;
		c = 8'h00;
		for (int i = nb - 1; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h31 : 8'h00);
		end
		return c;
	endfunction
	task automatic report_and_stop();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic send(input logic [7:0] c);
		sdsc_ctrl_model_inst.start();
		sdsc_ctrl_model_inst.wbyte({dev_addr, 1'b0}, ack);
		`CHK("addr ack", 1'b1, ack);
		sdsc_ctrl_model_inst.wbyte(c, ack);
		`CHK("cmd ack", 1'b1, ack);
		sdsc_ctrl_model_inst.stop();
	endtask
	task automatic rd(input logic [7:0] c, input int n);
		send(c);
		sdsc_ctrl_model_inst.start();
		sdsc_ctrl_model_inst.wbyte({dev_addr, 1'b1}, ack);
		`CHK("read addr ack", 1'b1, ack);
		for (int k = 0; k < n; k++) begin
			sdsc_ctrl_model_inst.rbyte(k == n - 1, rb[k]);
		end
		sdsc_ctrl_model_inst.stop();
	endtask
	task automatic diag(input logic [7:0] e);
		rd(8'h08, 2);
		`CHK("status", e, rb[0]);
		`CHK("status crc", crc8({8'h00, e}, 8), rb[1]);
		`CHK("zero remainder", 8'h00, crc8({rb[0], rb[1]}, 16));
	endtask
	initial begin
		#300_000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		srst = 1'b1;
		addr_sel = 1'b0;
		flags = 7'h00;
		temp_value = 16'h0000;
		hum_value = 16'h0000;
		dev_addr = 7'h40;
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		repeat (8) @(posedge mclk);
		`CHK("heater after reset", 1'b0, heater_on);
		`CHK("line free after reset", 1'b0, sda_oe);
		`CHK("data pin after reset", 1'b0, sda_data);
		for (int i = 0; i < 7; i++) begin
			flags <= 7'h01 << i;
			diag({7'h01 << i, 1'b0});
		end
		flags <= 7'h6E;
		diag(8'hDC);
		`CHK("known crc", 8'h79, rb[1]);
		flags <= 7'h00;
		$display("test status_bits done");
		send(8'h04);
		`CHK("heater on", 1'b1, heater_on);
		diag(8'h01);
		send(8'h02);
		`CHK("heater off", 1'b0, heater_on);
		diag(8'h00);
		send(8'h04);
		send(8'h1E);
		`CHK("heater reset", 1'b0, heater_on);
		`CHK("reset pulses", 1, resets);
		$display("test heater done");
		temp_value <= 16'h683A;
		hum_value <= 16'h4E85;
		rd(8'h00, 6);
		for (int k = 0; k < 6; k++) begin
			`CHK("trh byte", exp6[k], rb[k]);
		end
		rd(8'h10, 3);
		for (int k = 0; k < 3; k++) begin
			`CHK("rh byte", exp6[k + 3], rb[k]);
		end
		rd(8'h00, 2);
		`CHK("temp only", 8'h3A, rb[1]);
		temp_value <= 16'hFF00;
		rd(8'h00, 3);
		`CHK("clipped temp byte", 8'hFF, rb[0]);
		`CHK("clipped temp crc", crc8(16'hFF00, 16), rb[2]);
		rd(8'h0A, 1);
		`CHK("unknown cmd", 8'hFF, rb[0]);
		$display("test measure done");
		addr_sel <= 1'b1;
		repeat (4) @(posedge mclk);
		sdsc_ctrl_model_inst.start();
		sdsc_ctrl_model_inst.wbyte(8'h80, ack);
		`CHK("foreign addr ack", 1'b0, ack);
		sdsc_ctrl_model_inst.stop();
		dev_addr = 7'h41;
		diag(8'h00);
		$display("test address done");
		report_and_stop();
	end
endmodule
